/* File: include/sibs_pkg.sv */
// package of constants and types for the slow peripheral bus sequencer
package sibs_pkg;

    // ==========================================================
    // clock and delays
    localparam int CLK_PERIOD_NS = 8;
    localparam int ADDR_SETUP_NS = 16;
    localparam int ROM_ACCESS_NS = 32;
    localparam int IO_ACCESS_NS = 32;
    localparam int FLASH_PULSE_NS = 32;
    localparam int ADDR_HOLD_NS = 16;

    // least times round up; the 2-bit timer holds at most four cycles
    localparam int SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROM_CYC = (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IO_CYC = (IO_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLASH_CYC = (FLASH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // timer value seen in the last cycle of each timed phase
    localparam logic [1:0] SETUP_LAST = 2'(SETUP_CYC - 1);
    localparam logic [1:0] ROM_LAST = 2'(ROM_CYC - 1);
    localparam logic [1:0] IO_LAST = 2'(IO_CYC - 1);
    localparam logic [1:0] FLASH_LAST = 2'(FLASH_CYC - 1);
    localparam logic [1:0] HOLD_LAST = 2'(HOLD_CYC - 1);
    localparam logic [1:0] TIMER_RESET = 2'h0;
    localparam logic [1:0] TIMER_WRAP = 2'h3;

    // ==========================================================
    // packing counter
    localparam logic [1:0] PAK_BYTE0 = 2'h0;
    localparam logic [1:0] PAK_BYTE1 = 2'h1;
    localparam logic [1:0] PAK_BYTE2 = 2'h2;
    localparam logic [1:0] PAK_BYTE3 = 2'h3;

    // ==========================================================
    // address decode
    localparam int REGION_HI = 31;
    localparam int REGION_LO = 30;
    localparam logic [1:0] REGION_ROM = 2'h2;
    localparam logic [1:0] REGION_IO = 2'h3;
    localparam int FLASH_SEL_HI = 23;
    localparam int FLASH_SEL_LO = 22;

    // ==========================================================
    // strobe and latch on/off levels, and pin levels after reset
    localparam logic STROBE_OFF = 1'b1;
    localparam logic STROBE_ON = 1'b0;
    localparam logic LAT_OPEN = 1'b0;
    localparam logic LAT_HOLD = 1'b1;
    localparam logic RDY_IDLE = 1'b1;
    localparam logic ZWS_IDLE = 1'b1;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        OP_ROM_RD,
        OP_FLASH_WR,
        OP_IO_RD,
        OP_IO_WR
    } sibs_op_e;

    typedef enum logic {
        MN_IDLE,
        MN_WAIT
    } sibs_main_e;

    typedef enum logic [3:0] {
        SQ_IDLE,
        SQ_ROM,
        SQ_FL_SETUP,
        SQ_FL_PULSE,
        SQ_FL_HOLD,
        SQ_IO_SETUP,
        SQ_IO_STROBE,
        SQ_IO_LATCH,
        SQ_IO_HOLD,
        SQ_ACK,
        SQ_DONE
    } sibs_seq_e;

endpackage

/* File: logic/sibs_sync3.sv */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module sibs_sync3 #(
    parameter logic INIT = 1'b1
) (
    input wire logic clock_in, // system clock
    input wire logic rst_n_in, // synchronous reset, active low
    input wire logic pin_in,   // asynchronous pin level
    output logic level_out     // filtered synchronous level
);

    logic stage1;
    logic stage2;
    logic stage3;

    // ==========================================================
    // shift chain; a change counts once stages two and three agree
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
            level_out <= INIT;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level_out <= stage3;
            end
        end
    end

endmodule

/* File: logic/sibs_sequencer.sv */
// main cycle machine and i/o sequencer for the slow peripheral bus
// ==========================================================
// Overview of operation
// - stall cpu, request sequencer on i/o decode
// - keep cpu stalled until sequencer acknowledges
// - sequencer leaves idle on request
// - four byte reads form one word, counter addresses
// - counter cleared at start, steps to three
// - byte latch captures first and third bytes
// - word latch captures first two bytes
// - word lanes: word latch, byte latch, memory
// - acknowledge after fourth byte, wait released
// - drop request when memory request negated
// - one-clock acknowledge, one-cycle wait release
// - burst read wraps counter, repacks immediately
// - back to idle after last acknowledge
// - flash byte on low lane, strobe pulsed
// - flash counter loaded from address bits 23:22
// - shared 2-bit wrapping timer with clear
// - address setup before i/o read strobe
// - word latch, then read strobe one later
// - address hold then acknowledge
// - synchronised ready extends strobe
// - synchronised zero-wait ends strobe early
`timescale 1ns/1ps
module sibs_sequencer (
    input wire logic clock_in,          // 125 MHz memory clock
    input wire logic rst_n_in,          // synchronous reset, active low
    input wire logic cpu_mreq_n_in,     // cpu memory request, active low
    input wire logic cpu_write_in,      // cpu cycle is a write
    input wire logic [31:0] cpu_addr_in, // cpu address
    input wire logic io_rdy_in,         // peripheral ready pin, high = ready
    input wire logic io_zws_n_in,       // peripheral zero-wait pin, active low
    output logic cpu_wait_n_out,        // cpu wait, low stalls the cpu
    output logic [1:0] rom_addr_low_out, // boot/flash address bits 1:0
    output logic latch_byte_n_out,      // byte latch, high holds
    output logic latch_word_n_out,      // word latch, high holds
    output logic flash_wr_n_out,        // flash write strobe, active low
    output logic io_rd_n_out,           // i/o read strobe, active low
    output logic io_wr_n_out            // i/o write strobe, active low
);

    sibs_pkg::sibs_main_e main_state;
    sibs_pkg::sibs_seq_e seq_state;
    sibs_pkg::sibs_seq_e start_state;
    sibs_pkg::sibs_op_e op_kind;
    logic io_req;
    logic io_ack;
    logic [1:0] timer;
    logic [1:0] pak;
    logic clr_timer;
    logic rdy_sync;
    logic zws_n_sync;
    logic strobe_end;
    logic [1:0] region;

    assign region = cpu_addr_in[sibs_pkg::REGION_HI:sibs_pkg::REGION_LO];
    assign rom_addr_low_out = pak;

    // ==========================================================
    // pin synchronisers
    sibs_sync3 #(.INIT(sibs_pkg::RDY_IDLE)) u_rdy_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .pin_in(io_rdy_in),
        .level_out(rdy_sync)
    );

    sibs_sync3 #(.INIT(sibs_pkg::ZWS_IDLE)) u_zws_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .pin_in(io_zws_n_in),
        .level_out(zws_n_sync)
    );

    // ==========================================================
    // main cycle machine
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            main_state <= sibs_pkg::MN_IDLE;
            io_req <= 1'b0;
            cpu_wait_n_out <= 1'b1;
            op_kind <= sibs_pkg::OP_ROM_RD;
        end else begin
            unique case (main_state)
                sibs_pkg::MN_IDLE: begin
                    cpu_wait_n_out <= 1'b1;
                    if (!cpu_mreq_n_in && (region == sibs_pkg::REGION_ROM ||
                                           region == sibs_pkg::REGION_IO)) begin
                        io_req <= 1'b1;
                        cpu_wait_n_out <= 1'b0;
                        main_state <= sibs_pkg::MN_WAIT;
                        if (region == sibs_pkg::REGION_ROM) begin
                            op_kind <= cpu_write_in ? sibs_pkg::OP_FLASH_WR
                                                    : sibs_pkg::OP_ROM_RD;
                        end else begin
                            op_kind <= cpu_write_in ? sibs_pkg::OP_IO_WR
                                                    : sibs_pkg::OP_IO_RD;
                        end
                    end
                end
                sibs_pkg::MN_WAIT: begin
                    cpu_wait_n_out <= io_ack;
                    if (io_ack && cpu_mreq_n_in) begin
                        io_req <= 1'b0;
                        main_state <= sibs_pkg::MN_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // shared delay timer
    always_comb begin
        unique case (op_kind)
            sibs_pkg::OP_ROM_RD: start_state = sibs_pkg::SQ_ROM;
            sibs_pkg::OP_FLASH_WR: start_state = sibs_pkg::SQ_FL_SETUP;
            sibs_pkg::OP_IO_RD: start_state = sibs_pkg::SQ_IO_SETUP;
            sibs_pkg::OP_IO_WR: start_state = sibs_pkg::SQ_IO_SETUP;
        endcase
    end

    // ready stretches, zero-wait cuts the strobe short
    assign strobe_end = !zws_n_sync || (timer == sibs_pkg::IO_LAST && rdy_sync);

    always_comb begin
        unique case (seq_state)
            sibs_pkg::SQ_ROM: clr_timer = (timer == sibs_pkg::ROM_LAST);
            sibs_pkg::SQ_FL_SETUP: clr_timer = (timer == sibs_pkg::SETUP_LAST);
            sibs_pkg::SQ_FL_PULSE: clr_timer = (timer == sibs_pkg::FLASH_LAST);
            sibs_pkg::SQ_IO_SETUP: clr_timer = (timer == sibs_pkg::SETUP_LAST);
            sibs_pkg::SQ_IO_STROBE: clr_timer = strobe_end;
            sibs_pkg::SQ_FL_HOLD: clr_timer = 1'b0;
            sibs_pkg::SQ_IO_HOLD: clr_timer = 1'b0;
            default: clr_timer = 1'b1;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            timer <= sibs_pkg::TIMER_RESET;
        end else if (clr_timer) begin
            timer <= sibs_pkg::TIMER_RESET;
        end else begin
            timer <= timer + 2'h1;
        end
    end

    // ==========================================================
    // packing counter
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pak <= sibs_pkg::PAK_BYTE0;
        end else if (io_req && (seq_state == sibs_pkg::SQ_IDLE ||
                                seq_state == sibs_pkg::SQ_DONE)) begin
            if (op_kind == sibs_pkg::OP_FLASH_WR) begin
                pak <= cpu_addr_in[sibs_pkg::FLASH_SEL_HI:sibs_pkg::FLASH_SEL_LO];
            end else begin
                pak <= sibs_pkg::PAK_BYTE0;
            end
        end else if (seq_state == sibs_pkg::SQ_ROM && timer == sibs_pkg::ROM_LAST &&
                     pak != sibs_pkg::PAK_BYTE3) begin
            pak <= pak + 2'h1;
        end
    end

    // ==========================================================
    // i/o sequencer
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            seq_state <= sibs_pkg::SQ_IDLE;
            io_ack <= 1'b0;
            latch_byte_n_out <= sibs_pkg::LAT_OPEN;
            latch_word_n_out <= sibs_pkg::LAT_OPEN;
            flash_wr_n_out <= sibs_pkg::STROBE_OFF;
            io_rd_n_out <= sibs_pkg::STROBE_OFF;
            io_wr_n_out <= sibs_pkg::STROBE_OFF;
        end else begin
            io_ack <= 1'b0;
            unique case (seq_state)
                sibs_pkg::SQ_IDLE: begin
                    if (io_req) begin
                        seq_state <= start_state;
                    end
                end
                sibs_pkg::SQ_ROM: begin
                    if (timer == sibs_pkg::ROM_LAST) begin
                        unique case (pak)
                            sibs_pkg::PAK_BYTE0: latch_byte_n_out <= sibs_pkg::LAT_HOLD;
                            sibs_pkg::PAK_BYTE1: latch_word_n_out <= sibs_pkg::LAT_HOLD;
                            sibs_pkg::PAK_BYTE2: latch_byte_n_out <= sibs_pkg::LAT_HOLD;
                            sibs_pkg::PAK_BYTE3: begin
                                io_ack <= 1'b1;
                                seq_state <= sibs_pkg::SQ_ACK;
                            end
                        endcase
                    end else if (pak == sibs_pkg::PAK_BYTE2 &&
                                 timer == sibs_pkg::TIMER_RESET) begin
                        latch_byte_n_out <= sibs_pkg::LAT_OPEN; // reopen for third byte
                    end
                end
                sibs_pkg::SQ_FL_SETUP: begin
                    if (timer == sibs_pkg::SETUP_LAST) begin
                        flash_wr_n_out <= sibs_pkg::STROBE_ON;
                        seq_state <= sibs_pkg::SQ_FL_PULSE;
                    end
                end
                sibs_pkg::SQ_FL_PULSE: begin
                    if (timer == sibs_pkg::FLASH_LAST) begin
                        flash_wr_n_out <= sibs_pkg::STROBE_OFF;
                        seq_state <= sibs_pkg::SQ_FL_HOLD;
                    end
                end
                sibs_pkg::SQ_FL_HOLD: begin
                    if (timer == sibs_pkg::HOLD_LAST) begin
                        io_ack <= 1'b1;
                        seq_state <= sibs_pkg::SQ_ACK;
                    end
                end
                sibs_pkg::SQ_IO_SETUP: begin
                    if (timer == sibs_pkg::SETUP_LAST) begin
                        if (op_kind == sibs_pkg::OP_IO_RD) begin
                            io_rd_n_out <= sibs_pkg::STROBE_ON;
                        end else begin
                            io_wr_n_out <= sibs_pkg::STROBE_ON;
                        end
                        seq_state <= sibs_pkg::SQ_IO_STROBE;
                    end
                end
                sibs_pkg::SQ_IO_STROBE: begin
                    if (strobe_end) begin
                        if (op_kind == sibs_pkg::OP_IO_RD) begin
                            latch_word_n_out <= sibs_pkg::LAT_HOLD;
                        end
                        seq_state <= sibs_pkg::SQ_IO_LATCH;
                    end
                end
                sibs_pkg::SQ_IO_LATCH: begin
                    io_rd_n_out <= sibs_pkg::STROBE_OFF;
                    io_wr_n_out <= sibs_pkg::STROBE_OFF;
                    seq_state <= sibs_pkg::SQ_IO_HOLD;
                end
                sibs_pkg::SQ_IO_HOLD: begin
                    if (timer == sibs_pkg::HOLD_LAST) begin
                        io_ack <= 1'b1;
                        seq_state <= sibs_pkg::SQ_ACK;
                    end
                end
                sibs_pkg::SQ_ACK: begin
                    seq_state <= sibs_pkg::SQ_DONE;
                end
                sibs_pkg::SQ_DONE: begin
                    latch_byte_n_out <= sibs_pkg::LAT_OPEN;
                    latch_word_n_out <= sibs_pkg::LAT_OPEN;
                    seq_state <= io_req ? start_state : sibs_pkg::SQ_IDLE;
                end
                default: seq_state <= sibs_pkg::SQ_IDLE;
            endcase
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    stall_on_io_a: assert property (
        main_state == sibs_pkg::MN_IDLE && !cpu_mreq_n_in && region == sibs_pkg::REGION_IO
        |=> io_req && !cpu_wait_n_out)
        else $error("i/o access did not stall and request");
    hold_stall_a: assert property (
        main_state == sibs_pkg::MN_WAIT && !io_ack |=> !cpu_wait_n_out)
        else $error("cpu released before acknowledge");
    leave_idle_a: assert property (
        seq_state == sibs_pkg::SQ_IDLE && io_req |=> seq_state != sibs_pkg::SQ_IDLE)
        else $error("sequencer stayed idle on request");
    pak_step_a: assert property (
        seq_state == sibs_pkg::SQ_ROM && timer == sibs_pkg::ROM_LAST && pak != sibs_pkg::PAK_BYTE3
        |=> pak == 2'($past(pak) + 2'h1))
        else $error("packing counter did not step");
    byte_capture_a: assert property (
        seq_state == sibs_pkg::SQ_ROM && timer == sibs_pkg::ROM_LAST && pak == sibs_pkg::PAK_BYTE0
        |=> latch_byte_n_out && !latch_word_n_out ##4 latch_word_n_out && latch_byte_n_out)
        else $error("byte and word latch order wrong");
    ack_pulse_a: assert property (
        io_ack |=> !io_ack && cpu_wait_n_out ##1 !cpu_wait_n_out || main_state == sibs_pkg::MN_IDLE)
        else $error("acknowledge or wait release not one cycle");
    req_drop_a: assert property (
        io_ack && cpu_mreq_n_in |=> !io_req)
        else $error("request kept after last beat");
    burst_wrap_a: assert property (
        seq_state == sibs_pkg::SQ_DONE && io_req && op_kind == sibs_pkg::OP_ROM_RD
        |=> seq_state == sibs_pkg::SQ_ROM && pak == sibs_pkg::PAK_BYTE0)
        else $error("burst did not restart packing");
    idle_return_a: assert property (
        seq_state == sibs_pkg::SQ_DONE && !io_req |=> seq_state == sibs_pkg::SQ_IDLE)
        else $error("sequencer did not return to idle");
    flash_load_a: assert property (
        seq_state == sibs_pkg::SQ_IDLE && io_req && op_kind == sibs_pkg::OP_FLASH_WR
        |=> pak == $past(cpu_addr_in[23:22]) && flash_wr_n_out)
        else $error("flash counter not loaded from address");
    timer_wrap_a: assert property (
        !clr_timer && timer == sibs_pkg::TIMER_WRAP |=> timer == sibs_pkg::TIMER_RESET)
        else $error("timer did not wrap");
    read_hold_a: assert property (
        $rose(latch_word_n_out) && op_kind == sibs_pkg::OP_IO_RD
        |-> !io_rd_n_out ##1 io_rd_n_out)
        else $error("read strobe not held one cycle past latch");
    zws_cut_a: assert property (
        seq_state == sibs_pkg::SQ_IO_STROBE && !zws_n_sync |=> seq_state == sibs_pkg::SQ_IO_LATCH)
        else $error("zero-wait did not end strobe");

    rom_word_c: cover property (io_ack && op_kind == sibs_pkg::OP_ROM_RD);
    rom_burst_c: cover property (seq_state == sibs_pkg::SQ_DONE && io_req);
    flash_write_c: cover property ($fell(flash_wr_n_out));
    io_extend_c: cover property (seq_state == sibs_pkg::SQ_IO_STROBE && !rdy_sync);

endmodule

/* File: tb/sibs_far_side.sv */
// far-side peripheral model driving the ready and zero-wait pins
`timescale 1ns/1ps
module sibs_far_side (
    input wire logic clock_in,      // system clock
    input wire logic io_rd_n_in,    // read strobe, active low
    input wire logic io_wr_n_in,    // write strobe, active low
    input wire logic [7:0] slow_in, // strobe cycles kept not ready, 0 = prompt
    input wire logic zws_in,        // answer with zero-wait
    output logic io_rdy_out,        // ready pin, pulled up
    output logic io_zws_n_out       // zero-wait pin, pulled up
);
    logic strobe;
    logic freed;
    int held;
    assign strobe = !io_rd_n_in || !io_wr_n_in;
    initial begin
        held = 0;
        freed = 1'b0;
        io_rdy_out = 1'b1;
        io_zws_n_out = 1'b1;
    end
    // ready held low once armed, freed after enough strobe cycles
    always @(negedge clock_in) begin
        held <= strobe ? held + 1 : 0;
        freed <= (slow_in != 8'h00) && (freed || held + 1 >= int'(slow_in));
        io_rdy_out <= (slow_in == 8'h00) || freed;
        io_zws_n_out <= !(zws_in && strobe);
    end
endmodule

/* File: tb/test_slow_io_bus_sequencer.sv */
// self-checking bench for the slow peripheral bus sequencer
`timescale 1ns/1ps
module test_slow_io_bus_sequencer;
    localparam int RC = sibs_pkg::ROM_CYC;
    localparam int SC = sibs_pkg::SETUP_CYC;
    localparam int IC = sibs_pkg::IO_CYC;
    localparam int FC = sibs_pkg::FLASH_CYC;
    localparam int HC = sibs_pkg::HOLD_CYC;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cpu_mreq_n_in = 1'b1;
    logic cpu_write_in = 1'b0;
    logic [31:0] cpu_addr_in = 32'h0000_0000;
    logic [7:0] slow = 8'h00;
    logic zws = 1'b0;
    logic io_rdy, io_zws_n, wait_n, lat_b, lat_w, fl_n, rd_n, wr_n;
    logic [1:0] addr_low;
    logic wt_h [64];
    logic lb_h [64];
    logic lw_h [64];
    logic fl_h [64];
    logic rd_h [64];
    logic wr_h [64];
    logic [1:0] al_h [64];
    int fails = 0;
    int compares = 0;
    int cycles = 0;

    sibs_sequencer dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .cpu_mreq_n_in(cpu_mreq_n_in), .cpu_write_in(cpu_write_in),
        .cpu_addr_in(cpu_addr_in), .io_rdy_in(io_rdy), .io_zws_n_in(io_zws_n),
        .cpu_wait_n_out(wait_n), .rom_addr_low_out(addr_low),
        .latch_byte_n_out(lat_b), .latch_word_n_out(lat_w), .flash_wr_n_out(fl_n),
        .io_rd_n_out(rd_n), .io_wr_n_out(wr_n));
    sibs_far_side far_u (.clock_in(clock_in), .io_rd_n_in(rd_n), .io_wr_n_in(wr_n),
        .slow_in(slow), .zws_in(zws), .io_rdy_out(io_rdy), .io_zws_n_out(io_zws_n));

    // ==========================================================
    // clock, timeout and verdict
    always #4 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            summarize;
        end
    end
    task automatic summarize;
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================================
    // compares and helpers
    task automatic chk_lvl(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected level at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_cyc(input int got, input int exp);
        compares++;
        if (got != exp) begin
            fails++;
            $display("unexpected cycle at %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic chk_true(input bit ok);
        compares++;
        if (!ok) begin
            fails++;
            $display("unexpected cycle length at %0t", $time);
        end
    endtask
    function automatic int first_of(input logic h [64], input logic v, input int from);
        for (int i = from; i < 64; i++) begin
            if (h[i] === v) return i;
        end
        return -1;
    endfunction
    // one cpu cycle; index 0 is the cycle ended by the take edge
    task automatic xfer(input logic [31:0] a, input logic w, input int beats);
        int seen;
        seen = 0;
        cpu_addr_in = a;
        cpu_write_in = w;
        cpu_mreq_n_in = 1'b0;
        for (int k = 0; k < 64; k++) begin
            if (k > 0) @(negedge clock_in);
            wt_h[k] = wait_n;
            lb_h[k] = lat_b;
            lw_h[k] = lat_w;
            fl_h[k] = fl_n;
            rd_h[k] = rd_n;
            wr_h[k] = wr_n;
            al_h[k] = addr_low;
            if (k > 0 && wait_n === 1'b1) seen++;
            if (k > 0 && seen >= beats - 1) cpu_mreq_n_in = 1'b1;
        end
    endtask
    task automatic io_run(input logic w, output int s, output int e, output int p);
        xfer(32'hc000_0010, w, 1);
        if (w) begin
            s = first_of(wr_h, 1'b0, 0);
            e = first_of(wr_h, 1'b1, s);
        end else begin
            s = first_of(rd_h, 1'b0, 0);
            e = first_of(rd_h, 1'b1, s);
        end
        p = first_of(wt_h, 1'b1, 1);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        repeat (8) @(negedge clock_in);
        chk_lvl({wait_n, fl_n, rd_n, wr_n}, 4'hf);
        chk_lvl({addr_low, lat_b, lat_w}, 4'h0);
        rst_n_in = 1'b1;
    endtask
    task automatic t_rom;
        int p;
        xfer(32'h8000_0000, 1'b0, 1);
        for (int b = 0; b < 4; b++) begin
            chk_lvl(4'(al_h[3 + RC * b]), 4'(b));
        end
        chk_cyc(first_of(lb_h, 1'b1, 0), 2 + RC);
        chk_cyc(first_of(lw_h, 1'b1, 0), 2 + 2 * RC);
        chk_cyc(first_of(lb_h, 1'b1, 3 + 2 * RC), 2 + 3 * RC);
        p = first_of(wt_h, 1'b1, 1);
        chk_cyc(p, 3 + 4 * RC);
        chk_lvl(4'({wt_h[p - 1], lw_h[p - 1], lb_h[p - 1]}), 4'h3);
        chk_lvl(4'({wt_h[p + 4], lw_h[p + 4], lb_h[p + 4]}), 4'h4);
    endtask
    task automatic t_burst;
        int p, q;
        xfer(32'h8000_0010, 1'b0, 2);
        p = first_of(wt_h, 1'b1, 1);
        q = first_of(wt_h, 1'b1, p + 1);
        chk_lvl(4'({wt_h[p + 1], al_h[p + 1]}), 4'h0);
        chk_cyc(q - p, 4 * RC + 2);
        chk_cyc(first_of(wt_h, 1'b0, q), -1);
    endtask
    task automatic t_flash;
        int s, e;
        for (int sel = 3; sel >= 0; sel--) begin
            xfer({8'h80, 2'(sel), 22'h0}, 1'b1, 1);
            s = first_of(fl_h, 1'b0, 0);
            e = first_of(fl_h, 1'b1, s);
            chk_cyc(s, 2 + SC);
            chk_cyc(e - s, FC);
            chk_lvl(4'(al_h[s]), 4'(sel));
            chk_cyc(first_of(wt_h, 1'b1, 1), e + HC + 1);
        end
    endtask
    task automatic t_io_read;
        int s, e, p;
        io_run(1'b0, s, e, p);
        chk_lvl(4'({wt_h[1], wt_h[e]}), 4'h0);
        chk_cyc(s, 2 + SC);
        chk_cyc(e - first_of(lw_h, 1'b1, 0), 1);
        chk_cyc(e - s, IC + 1);
        chk_cyc(p, e + HC + 1);
    endtask
    task automatic t_io_rdy;
        int s, e, p;
        slow = 8'h0a;
        io_run(1'b1, s, e, p);
        slow = 8'h00;
        chk_true(e - s >= 10 && e - s > IC + 1);
        chk_cyc(p, e + HC + 1);
    endtask
    task automatic t_io_zws;
        int s, e, p;
        // ready held low too, so only zero-wait can end the strobe early
        slow = 8'h0a;
        zws = 1'b1;
        io_run(1'b0, s, e, p);
        slow = 8'h00;
        zws = 1'b0;
        chk_true(s > 0 && e - s <= IC + 2);
        chk_cyc(p, e + HC + 1);
    endtask
    task automatic t_other;
        xfer(32'h4000_0000, 1'b0, 1);
        chk_cyc(first_of(wt_h, 1'b0, 0), -1);
        chk_cyc(first_of(rd_h, 1'b0, 0), -1);
    endtask

    initial begin
        t_reset;
        t_rom;
        t_burst;
        t_flash;
        t_io_read;
        t_io_rdy;
        t_io_zws;
        t_other;
        summarize;
    end
endmodule
